//--- flash_ctrl_defines.svh
// Register offsets, field positions, codes and timing counts for the flash self-program controller
`ifndef FLASH_CTRL_DEFINES_SVH
`define FLASH_CTRL_DEFINES_SVH
`define REG_CONTROL 3'h0
`define REG_ADDR_HIGH 3'h1
`define REG_ADDR_LOW 3'h2
`define REG_UNLOCK_KEY 3'h3
`define REG_TABLE_PAGE 3'h4
`define BIT_START 15
`define BIT_WRITE_ENABLE_BIT 14
`define BIT_SEQERR 13
`define BIT_IDLE_SB 12
`define OP_PAGE_ERASE 4'h3
`define OP_DWORD_PROG 4'h1
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
`define TBL_CFG_BIT 7
`define ERASE_CYCLES 20'h00400
`define PROG_CYCLES 20'h00100
`define WAKE_CYCLES 20'h00040
`define ZERO16 16'h0000
`define ZERO8 8'h00
`endif

//--- flash_ctrl_pkg.sv
// Types shared by the flash self-program controller
package flash_ctrl_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [23:0] wdata;
    logic [23:0] wdata2;
    logic erase;
    logic prog;
    logic tbl_wr;
  } flash_cmd_t;
  typedef struct packed {
    logic [15:0] ea;
    logic high;
    logic byte_mode;
    logic rd;
    logic wr;
    logic [15:0] wdata;
  } table_req_t;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_WAKE} fsm_state_t;
endpackage

//--- flash_self_program_control.sv
// Flash self-program controller: table access, unlock, control registers and operation timing
// Summary of operation
// - Table address is table page low byte joined to the effective address.
// - Low-word table accesses use program bits 15 to 0.
// - High-word table accesses use program bits 23 to 16.
// - Processor stalls while an erase or program runs.
// - Start bit 15 launches a timed operation; hardware clears it at end.
// - Program writes two adjacent words at a double-word aligned address; the code sends the program address with bits 1-0 set to 10.
// - Key writes 0x55 then 0xAA must precede any operation.
// - Address high gives upper eight bits, address low the lower sixteen.
// - Write-enable bit 14 permits operations when set, inhibits when clear.
// - Sequence-error bit 13 flags improper sequences or terminated operations.
// - Idle-standby bit 12 puts regulator in standby during Idle.
// - Select code 0011 erases a page, 0001 programs; others do nothing.
// - Enable, error and select reset on power-on; start also on brown-out.
// - Power-saving instruction is ignored while an operation runs.
// - Start bit can be set by software but never cleared by it.
// - Key register is write-only; unused bits and control bits 11-4 read zero.
// - With idle standby set, flash waits a wake delay after Idle.
// - Table page bit 7 selects user or configuration space.
// - High-word word read returns program bits 23-16 with upper byte zero.
// - Low-word byte read picks upper byte when byte select is one.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "flash_ctrl_defines.svh"
module flash_self_program_control (
  input wire logic clk_sys_i, // 40 MHz system clock
  input wire logic arst_n_i, // Power-on reset, active low
  input wire logic bor_n_i, // Brown-out reset, active low, synchronous
  input wire flash_ctrl_pkg::reg_req_t reg_req_i, // Register bus request
  output logic [15:0] reg_rdata_o, // Register read data, one cycle later
  input wire flash_ctrl_pkg::table_req_t tbl_req_i, // Table read or write request
  output logic [15:0] tbl_rdata_o, // Table read data, two cycles later
  input wire logic [23:0] flash_rdata_i, // Flash array word at flash_addr_o
  output logic [23:0] flash_addr_o, // Flash array read address
  output flash_ctrl_pkg::flash_cmd_t flash_cmd_o, // Flash array command
  input wire logic idle_i, // Core is in Idle mode
  input wire logic power_save_instruction_req_i, // Core executes power-saving instruction
  output logic power_save_instruction_ok_o, // Power-saving instruction accepted
  output logic stall_o, // Processor stall
  output logic reg_standby_o, // Flash regulator standby
  output logic flash_space_cfg_o // Table page in configuration space
);
  import flash_ctrl_pkg::*;

  // Sequencer state
  fsm_state_t state;
  fsm_state_t next_state;
  // Control register fields
  logic start;
  logic write_enable_bit;
  logic seqerr;
  logic idle_sb;
  logic [3:0] opsel;
  // Target address and table page
  logic [7:0] addr_high;
  logic [15:0] addr_low;
  logic [7:0] table_page;
  // Key tracker, operation counter and Idle edge
  logic [1:0] key_stage;
  logic [19:0] count;
  logic [19:0] next_count;
  logic idle_d;
  // Double-word program latches, slot 0 even word, slot 1 odd word
  logic [23:0] latch [2];
  // Table read pipeline
  logic tbl_high_q;
  logic tbl_byte_q;
  logic tbl_bsel_q;
  logic tbl_rd_q;
  // Read data next values
  logic [15:0] next_rdata;
  logic [15:0] next_tbl_rdata;

  // Register decoding
  wire wr_ctl = reg_req_i.wr && (reg_req_i.addr == `REG_CONTROL);
  wire wr_key = reg_req_i.wr && (reg_req_i.addr == `REG_UNLOCK_KEY);
  // A start write only counts while the bit is clear
  wire start_req = wr_ctl && reg_req_i.wdata[`BIT_START] && !start;
  wire unlocked = (key_stage == 2'h2);
  wire [3:0] new_op = reg_req_i.wdata[3:0];
  // Only the two defined codes launch anything; every other code is a refused start
  wire new_erase = (new_op == `OP_PAGE_ERASE);
  wire new_prog = (new_op == `OP_DWORD_PROG);
  // Sequencer must be idle too: after a brown-out the bit is clear while the array is still busy
  wire start_ok = start_req && unlocked && reg_req_i.wdata[`BIT_WRITE_ENABLE_BIT]
                  && (new_erase || new_prog) && (state == ST_IDLE);
  wire start_bad = start_req && !start_ok;
  wire [23:0] target = {addr_high, addr_low};
  wire op_done = (state == ST_BUSY) && (count == 20'h00000);
  // Falling edge of Idle; idle_d resets low like the pin, so reset gives no false edge
  wire idle_exit = idle_d && !idle_i;

  // Table address from page and effective address
  wire [23:0] tbl_addr = {table_page, tbl_req_i.ea[15:1], 1'b0};

  // Key sequence tracker
  // A first key always restarts the sequence, so a stray write between keys cannot
  // leave a half-armed unlock behind; any other write drops back to locked
  function automatic logic [1:0] key_next(input logic [1:0] st, input logic kw, input logic anyw,
                                            input logic [7:0] kv);
    if (kw && kv == `KEY_FIRST)
      key_next = 2'h1;
    else if (kw && kv == `KEY_SECOND && st == 2'h1)
      key_next = 2'h2;
    else if (anyw)
      key_next = 2'h0;
    else
      key_next = st;
  endfunction

  // Cycle budget of the operation being launched
  function automatic logic [19:0] op_cycles(input logic erase);
    if (erase)
      op_cycles = `ERASE_CYCLES;
    else
      op_cycles = `PROG_CYCLES;
  endfunction

  // Operation sequencer
  // The counter is loaded at launch and run down to zero, so an operation lasts its
  // budget plus one cycle; the wake delay after Idle reuses the same counter
  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      ST_IDLE:
        if (start_ok)
        begin
          next_state = ST_BUSY;
          next_count = op_cycles(new_erase);
        end
        else if (idle_exit && idle_sb)
        begin
          next_state = ST_WAKE;
          next_count = `WAKE_CYCLES;
        end
      ST_BUSY:
        if (op_done)
          next_state = ST_IDLE;
        else
          next_count = count - 20'h00001;
      ST_WAKE:
        if (count == 20'h00000)
          next_state = ST_IDLE;
        else
          next_count = count - 20'h00001;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Register read selection
  // Decoded from the address alone; the read strobe gates the output register
  // The key register falls into the final branch and always reads zero
  always_comb
  begin
    next_rdata = `ZERO16;
    if (reg_req_i.addr == `REG_CONTROL)
      next_rdata = {start, write_enable_bit, seqerr, idle_sb, 8'h00, opsel};
    else if (reg_req_i.addr == `REG_ADDR_HIGH)
      next_rdata = {`ZERO8, addr_high};
    else if (reg_req_i.addr == `REG_ADDR_LOW)
      next_rdata = addr_low;
    else if (reg_req_i.addr == `REG_TABLE_PAGE)
      next_rdata = {`ZERO8, table_page};
    else
      next_rdata = `ZERO16;
  end

  // Table read data shaping
  // Mode bits are delayed one cycle to line up with the word the array returns
  // for the registered address; the phantom upper byte always reads zero
  always_comb
  begin
    next_tbl_rdata = `ZERO16;
    if (!tbl_high_q && !tbl_byte_q)
      next_tbl_rdata = flash_rdata_i[15:0];
    else if (!tbl_high_q)
      next_tbl_rdata = {`ZERO8, tbl_bsel_q ? flash_rdata_i[15:8] : flash_rdata_i[7:0]};
    else if (!tbl_byte_q || !tbl_bsel_q)
      next_tbl_rdata = {`ZERO8, flash_rdata_i[23:16]};
    else
      next_tbl_rdata = `ZERO16;
  end

  // Start bit, reset by power-on or brown-out
  // Brown-out clears only this bit; the other control fields survive it
  // A start is accepted only while idle, so it never meets the completion clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      start <= 1'b0;
    else if (!bor_n_i)
      start <= 1'b0;
    else if (start_ok)
      start <= 1'b1;
    else if (op_done)
      start <= 1'b0;
  end

  // Power-on-only control bits
  // Enable, select and idle-standby fields are frozen while the start bit is set so the running command cannot change;
  // a refused start or a cut operation sets the error flag and wins over a clear
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      write_enable_bit <= 1'b0;
      seqerr <= 1'b0;
      opsel <= 4'h0;
      idle_sb <= 1'b0;
    end
    else
    begin
      if (wr_ctl && !start)
      begin
        write_enable_bit <= reg_req_i.wdata[`BIT_WRITE_ENABLE_BIT];
        opsel <= reg_req_i.wdata[3:0];
        idle_sb <= reg_req_i.wdata[`BIT_IDLE_SB];
      end
      if (start_bad || (state == ST_BUSY && !bor_n_i))
        seqerr <= 1'b1;
      else if (start_ok)
        seqerr <= 1'b0;
      else if (wr_ctl)
        seqerr <= reg_req_i.wdata[`BIT_SEQERR];
    end
  end

  // Address, page, key and sequencer state
  // Address registers are cleared at reset as well, so early reads are defined
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      addr_high <= `ZERO8;
      addr_low <= `ZERO16;
      table_page <= `ZERO8;
      key_stage <= 2'h0;
      state <= ST_IDLE;
      count <= 20'h00000;
      idle_d <= 1'b0;
    end
    else
    begin
      if (reg_req_i.wr && reg_req_i.addr == `REG_ADDR_HIGH)
        addr_high <= reg_req_i.wdata[7:0];
      if (reg_req_i.wr && reg_req_i.addr == `REG_ADDR_LOW)
        addr_low <= reg_req_i.wdata;
      if (reg_req_i.wr && reg_req_i.addr == `REG_TABLE_PAGE)
        table_page <= reg_req_i.wdata[7:0];
      key_stage <= key_next(key_stage, wr_key, reg_req_i.wr, reg_req_i.wdata[7:0]);
      state <= next_state;
      count <= next_count;
      idle_d <= idle_i;
    end
  end

  // Table write latches hold the double word to program
  // Word-address bit 1 picks the slot; high writes fill bits 23-16, low writes 15-0
  for (genvar s = 0; s < 2; s++)
  begin : g_latch
    wire slot_hit = tbl_req_i.wr && (tbl_addr[1] == 1'(s));
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
        latch[s] <= 24'h000000;
      else if (slot_hit)
        latch[s] <= tbl_req_i.high ? {tbl_req_i.wdata[7:0], latch[s][15:0]}
                                   : {latch[s][23:16], tbl_req_i.wdata};
    end
  end

  // Table read pipeline and data
  // Data read zero outside the answer cycle, so a stale word never looks like an answer
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tbl_high_q <= 1'b0;
      tbl_byte_q <= 1'b0;
      tbl_bsel_q <= 1'b0;
      tbl_rd_q <= 1'b0;
      flash_addr_o <= 24'h000000;
      tbl_rdata_o <= `ZERO16;
    end
    else
    begin
      tbl_rd_q <= tbl_req_i.rd;
      tbl_high_q <= tbl_req_i.high;
      tbl_byte_q <= tbl_req_i.byte_mode;
      tbl_bsel_q <= tbl_req_i.ea[0];
      if (tbl_req_i.rd)
        flash_addr_o <= tbl_addr;
      tbl_rdata_o <= tbl_rd_q ? next_tbl_rdata : `ZERO16;
    end
  end

  // Outputs toward core and flash array
  // Command fields follow the current write every cycle; only the one-cycle erase
  // and program pulses mean anything. Stall comes from the next state so it rises
  // on the launch edge. Power-save is refused in any cycle in which the sequencer
  // is, or is about to become, busy or waking.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_rdata_o <= `ZERO16;
      flash_cmd_o <= '0;
      stall_o <= 1'b0;
      power_save_instruction_ok_o <= 1'b0;
      reg_standby_o <= 1'b0;
      flash_space_cfg_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o <= reg_req_i.rd ? next_rdata : `ZERO16;
      flash_cmd_o.addr <= new_prog ? {target[23:2], 2'b10} : target;
      flash_cmd_o.wdata <= latch[0];
      flash_cmd_o.wdata2 <= latch[1];
      flash_cmd_o.erase <= start_ok && new_erase;
      flash_cmd_o.prog <= start_ok && new_prog;
      flash_cmd_o.tbl_wr <= tbl_req_i.wr;
      stall_o <= (next_state != ST_IDLE);
      power_save_instruction_ok_o <= power_save_instruction_req_i && (state == ST_IDLE) && (next_state == ST_IDLE);
      reg_standby_o <= idle_i && idle_sb && (state == ST_IDLE);
      flash_space_cfg_o <= table_page[`TBL_CFG_BIT];
    end
  end
endmodule // flash_self_program_control

//--- flash_array_model.sv
// Flash array model: returns a word derived from the read address
`timescale 1ns/1ps
module flash_array_model (
  input wire logic [23:0] addr_i, // Read address
  output logic [23:0] rdata_o // Word at addr_i
);
  // Pattern from address bits 16-1, so a wrong address in those bits gives wrong data
  assign rdata_o = {addr_i[8:1] ^ 8'h5A, addr_i[16:1] ^ 16'hC3A5};
endmodule // flash_array_model

//--- flash_self_program_control_monitor.sv
// Assertion checker for the flash self-program controller ports
`timescale 1ns/1ps
module flash_self_program_control_monitor (
  input wire logic clk_sys_i, // Clock
  input wire logic arst_n_i, // Reset
  input wire logic bor_n_i, // Brown-out
  input wire flash_ctrl_pkg::reg_req_t reg_req_i, // Register request
  input wire logic [15:0] reg_rdata_o, // Register data
  input wire flash_ctrl_pkg::table_req_t tbl_req_i, // Table request
  input wire logic [15:0] tbl_rdata_o, // Table data
  input wire logic [23:0] flash_rdata_i, // Array word
  input wire logic [23:0] flash_addr_o, // Array address
  input wire flash_ctrl_pkg::flash_cmd_t flash_cmd_o, // Array command
  input wire logic idle_i, // Idle
  input wire logic power_save_instruction_req_i, // Power save request
  input wire logic power_save_instruction_ok_o, // Power save accepted
  input wire logic stall_o, // Stall
  input wire logic reg_standby_o, // Standby
  input wire logic flash_space_cfg_o // Config space
);
  import flash_ctrl_pkg::*;
  // One clock domain, one reset
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_start_cause;
    (flash_cmd_o.erase || flash_cmd_o.prog) |-> $past(reg_req_i.wr && reg_req_i.addr == 3'h0 && reg_req_i.wdata[15] && reg_req_i.wdata[14]);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("operation without enabled start write");
  property p_stall_hold;
    flash_cmd_o.erase |-> stall_o [*8];
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall not held during erase");
  property p_prog_addr;
    flash_cmd_o.prog |-> !flash_cmd_o.erase && flash_cmd_o.addr[1:0] == 2'h2;
  endproperty
  a_prog_addr: assert property (p_prog_addr) else $error("bad program command");
  property p_power_save_instruction;
    stall_o |-> !power_save_instruction_ok_o;
  endproperty
  a_power_save_instruction: assert property (p_power_save_instruction) else $error("power save accepted while busy");
  property p_standby;
    reg_standby_o |-> $past(idle_i);
  endproperty
  a_standby: assert property (p_standby) else $error("standby outside idle");
  property p_key_rd;
    reg_req_i.rd && reg_req_i.addr == 3'h3 |=> reg_rdata_o == 16'h0000;
  endproperty
  a_key_rd: assert property (p_key_rd) else $error("key register readable");
  property p_ctl_rd;
    reg_req_i.rd && reg_req_i.addr == 3'h0 |=> reg_rdata_o[11:4] == 8'h00;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control unused bits set");
  property p_adrh_rd;
    reg_req_i.rd && reg_req_i.addr == 3'h1 |=> reg_rdata_o[15:8] == 8'h00;
  endproperty
  a_adrh_rd: assert property (p_adrh_rd) else $error("address high upper byte set");
  property p_high_rd;
    tbl_req_i.rd && tbl_req_i.high && !tbl_req_i.byte_mode |-> ##2 tbl_rdata_o[15:8] == 8'h00;
  endproperty
  a_high_rd: assert property (p_high_rd) else $error("high word read upper byte set");
  property p_tbl_addr;
    tbl_req_i.rd |=> flash_addr_o[15:0] == {$past(tbl_req_i.ea[15:1]), 1'b0};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
endmodule // flash_self_program_control_monitor
bind flash_self_program_control flash_self_program_control_monitor u_mon (.clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i), .bor_n_i(bor_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .tbl_req_i(tbl_req_i), .tbl_rdata_o(tbl_rdata_o), .flash_rdata_i(flash_rdata_i), .flash_addr_o(flash_addr_o),
  .flash_cmd_o(flash_cmd_o), .idle_i(idle_i), .power_save_instruction_req_i(power_save_instruction_req_i), .power_save_instruction_ok_o(power_save_instruction_ok_o),
  .stall_o(stall_o), .reg_standby_o(reg_standby_o), .flash_space_cfg_o(flash_space_cfg_o));

//--- tb_flash_self_program_control.sv
// Self-checking testbench for the flash self-program controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_flash_self_program_control;
  import flash_ctrl_pkg::*;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, bor_n_i = 1'b1, idle_i = 1'b0, power_save_instruction_req_i = 1'b0;
  reg_req_t rq = '0;
  table_req_t tq = '0;
  flash_cmd_t cmd;
  logic [15:0] rdat, tdat;
  logic [23:0] fad, frd, w;
  logic [31:0] seed = 32'h00008729, a;
  logic ok, stall, sb, cfg, e;
  int errors = 0, n_tests = 0, cyc = 0;
  flash_self_program_control DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bor_n_i(bor_n_i), .reg_req_i(rq),
    .reg_rdata_o(rdat), .tbl_req_i(tq), .tbl_rdata_o(tdat), .flash_rdata_i(frd), .flash_addr_o(fad),
    .flash_cmd_o(cmd), .idle_i(idle_i), .power_save_instruction_req_i(power_save_instruction_req_i), .power_save_instruction_ok_o(ok), .stall_o(stall),
    .reg_standby_o(sb), .flash_space_cfg_o(cfg));
  flash_array_model mem (.addr_i(fad), .rdata_o(frd));
  // Clock and hang guard
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected table read data from the array word and access mode
  function automatic logic [15:0] tbl_exp(logic [23:0] x, logic hi, logic bm, logic bs);
    if (!hi)
      return bm ? {8'h00, bs ? x[15:8] : x[7:0]} : x[15:0];
    return (bm && bs) ? 16'h0000 : {8'h00, x[23:16]};
  endfunction
  task automatic wr(input logic [2:0] ad, input logic [15:0] d);
    rq <= '{ad, d, 1'b1, 1'b0};
    @(posedge clk_sys_i);
  endtask
  task automatic idle();
    rq <= '0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [2:0] ad, input logic [15:0] x);
    rq <= '{ad, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys_i);
    rq <= '0;
    #1 `CHK(rdat, x)
    @(posedge clk_sys_i);
  endtask
  // Key pair, control write, then launch check
  task automatic go(input logic [15:0] c, input logic ex, input logic [23:0] x);
    wr(3'h3, 16'h0055);
    wr(3'h3, 16'h00AA);
    wr(3'h0, c);
    rq <= '0;
    #1 `CHK(stall, ex)
    `CHK({cmd.erase, cmd.prog}, ex ? {c[3:0] == 4'h3, c[3:0] == 4'h1} : 2'h0)
    if (ex)
      `CHK(cmd.addr, x)
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 1100 && stall !== 1'b0; i++)
      @(posedge clk_sys_i);
    #1 `CHK(stall, 1'b0)
    @(posedge clk_sys_i);
  endtask
  task automatic pulse_power_save_instruction(input logic x);
    power_save_instruction_req_i <= 1'b1;
    @(posedge clk_sys_i);
    power_save_instruction_req_i <= 1'b0;
    #1 `CHK(ok, x)
    @(posedge clk_sys_i);
  endtask
  task automatic report_and_stop();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(3'h0, 16'h0000);
    rd(3'h3, 16'h0000);
    rd(3'h5, 16'h0000);
    a = rnd();
    wr(3'h1, a[15:0]);
    wr(3'h2, a[31:16]);
    rd(3'h1, {8'h00, a[7:0]});
    rd(3'h2, a[31:16]);
    for (int i = 0; i < 40; i++)
    begin
      a = rnd();
      wr(3'h4, {8'h00, a[31:24]});
      tq <= '{a[15:0], a[16], a[17], 1'b1, 1'b0, 16'h0000};
      rq <= '0;
      @(posedge clk_sys_i);
      tq <= '0;
      #1 `CHK(fad, {a[31:24], a[15:1], 1'b0})
      `CHK(cfg, a[31])
      w = frd;
      @(posedge clk_sys_i);
      #1 `CHK(tdat, tbl_exp(w, a[16], a[17], a[0]))
      @(posedge clk_sys_i);
    end
    // Table writes fill both words of the program pair
    a = rnd();
    tq <= '{16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, a[15:0]};
    @(posedge clk_sys_i);
    tq <= '{16'h0000, 1'b1, 1'b0, 1'b0, 1'b1, {8'h00, a[23:16]}};
    @(posedge clk_sys_i);
    tq <= '{16'h0002, 1'b0, 1'b0, 1'b0, 1'b1, a[31:16]};
    @(posedge clk_sys_i);
    tq <= '{16'h0002, 1'b1, 1'b0, 1'b0, 1'b1, {8'h00, a[7:0]}};
    @(posedge clk_sys_i);
    tq <= '0;
    #1 `CHK(cmd.tbl_wr, 1'b1)
    @(posedge clk_sys_i);
    #1 `CHK(cmd.wdata, a[23:0])
    `CHK(cmd.wdata2, {a[7:0], a[31:16]})
    `CHK(cmd.tbl_wr, 1'b0)
    @(posedge clk_sys_i);
    wr(3'h1, 16'h0012);
    wr(3'h2, 16'h3404);
    go(16'hC003, 1'b1, 24'h123404);
    pulse_power_save_instruction(1'b0);
    rd(3'h0, 16'hC003);
    wr(3'h0, 16'h0000);
    idle();
    wait_done();
    rd(3'h0, 16'h4003);
    pulse_power_save_instruction(1'b1);
    for (int c = 0; c < 16; c++)
    begin
      e = (c == 1 || c == 3);
      go({4'hC, 8'h00, c[3:0]}, e, c == 1 ? 24'h123406 : 24'h123404);
      wait_done();
      rd(3'h0, {2'h1, ~e, 9'h000, c[3:0]});
    end
    wr(3'h3, 16'h0055);
    wr(3'h3, 16'h00AA);
    wr(3'h1, 16'h0012);
    go(16'h8003, 1'b0, 24'h000000);
    rd(3'h0, 16'h2003);
    wr(3'h3, 16'h0055);
    wr(3'h3, 16'h00AA);
    wr(3'h1, 16'h0012);
    wr(3'h0, 16'hC003);
    idle();
    rd(3'h0, 16'h6003);
    go(16'hC003, 1'b1, 24'h123404);
    bor_n_i <= 1'b0;
    @(posedge clk_sys_i);
    bor_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(3'h0, 16'h6003);
    wait_done();
    wr(3'h0, 16'h5000);
    rq <= '0;
    idle_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    idle_i <= 1'b0;
    #1 `CHK(sb, 1'b1)
    repeat (3) @(posedge clk_sys_i);
    #1 `CHK(stall, 1'b1)
    `CHK(sb, 1'b0)
    @(posedge clk_sys_i);
    pulse_power_save_instruction(1'b0);
    wait_done();
    report_and_stop();
  end
endmodule // tb_flash_self_program_control
